// [fsac_pkg.sv]
// flash security access control: shared constants and types
// assumes a byte-wide register port and byte-wide flash
package fsac_pkg;
   // flash geometry
   localparam int FLASH_BYTES = 16384;
   localparam int PAGE_BYTES = 512;
   localparam int USER_BYTES = 15872;
   // data values
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] KEY_FIRST = 8'ha5;
   localparam logic [7:0] KEY_SECOND = 8'hf1;
   // register offsets
   localparam logic [7:0] REG_STORE = 8'h00;
   localparam logic [7:0] REG_KEY = 8'h04;
   localparam logic [7:0] REG_RSRC = 8'h08;
   localparam logic [7:0] REG_SUPPLY = 8'h0c;
   localparam logic [7:0] REG_LOCK = 8'h10;
   // field positions
   localparam int SWE_BIT = 0;
   localparam int SEE_BIT = 1;
   localparam int PORF_BIT = 0;
   localparam int MONRST_BIT = 1;
   localparam int FERR_BIT = 6;
   localparam int MONEN_BIT = 0;
   localparam int LOCKED_BIT = 0;
   // reset values
   localparam logic STORE_RST = 1'b0;
   localparam logic MON_RST = 1'b1;
   localparam logic PORF_RST = 1'b1;
   localparam logic FERR_RST = 1'b0;
   // firmware access kinds, flash operations, access verdicts and key states
   typedef enum logic [1:0] {K_CODE_RD, K_EXT_RD, K_EXT_WR} fsac_kind_e;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE, OP_FULL} fsac_op_e;
   typedef enum logic [1:0] {V_ALLOW, V_DENY, V_FLASH_ERROR_RESET} fsac_verdict_e;
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN, KEY_DEAD} fsac_key_e;
endpackage : fsac_pkg

// [fsac_mem.sv]
// flash array model: byte memory with registered read data
// assumes one access per cycle; starts out erased
`timescale 1ns/1ps
module fsac_mem #(
   parameter int AW = 14,
   parameter int DW = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // access port
   input wire logic en,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);
   // a fresh part is fully erased; set at declaration so the write port stays the only writer
   logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '1};

   // write port
   always_ff @(posedge clk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
   end

   // read data holds until the next read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (en && !we) begin
         rdata <= mem[addr];
      end
   end
endmodule : fsac_mem

// [fsac_top.sv]
// flash security access control: registers, key, lock and access checks
// assumes firmware and debug requesters run on clk and hold req until ack
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module fsac_top import fsac_pkg::*; #(
   parameter int FLASH_SIZE = FLASH_BYTES,
   parameter int PAGE_SIZE = PAGE_BYTES,
   parameter int USER_SIZE = USER_BYTES,
   localparam int AW = $clog2(FLASH_SIZE),
   localparam int PW = $clog2(PAGE_SIZE)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // firmware access
   input wire logic fw_req,
   input wire fsac_kind_e fw_kind,
   input wire logic [AW-1:0] fw_addr,
   input wire logic [7:0] fw_wdata,
   input wire logic [AW-1:0] fw_pc,
   output logic [7:0] fw_rdata,
   output logic fw_ack,
   output logic external_data_ram_req,
   output logic cpu_stall,
   output logic flash_error_reset,
   // serial debug port access
   input wire logic dbg_req,
   input wire fsac_op_e dbg_op,
   input wire logic [AW-1:0] dbg_addr,
   input wire logic [7:0] dbg_wdata,
   output logic [7:0] dbg_rdata,
   output logic dbg_ack,
   output logic dbg_deny
);
   localparam logic [AW-1:0] LOCK_ADDR = AW'(USER_SIZE - 1);
   localparam logic [AW-PW-1:0] LOCK_PG = LOCK_ADDR[AW-1:PW];

   // geometry the address slicing can serve
   if (FLASH_SIZE != (1 << AW) || PAGE_SIZE != (1 << PW) || USER_SIZE % PAGE_SIZE != 0
       || USER_SIZE > FLASH_SIZE || USER_SIZE < PAGE_SIZE) begin : g_bad
      $error("fsac_top: unsupported flash geometry");
   end

   typedef enum logic [3:0] {ST_INIT, ST_INITW, ST_IDLE, ST_READ, ST_RWAIT, ST_WREAD,
                             ST_WRITE, ST_ERASE, ST_DONE, ST_FERR} fsac_state_e;

   fsac_state_e st_q, st_d;
   fsac_key_e key_q;
   logic swe_q, see_q, mon_en_q, mon_rst_q, por_q, ferr_q;
   logic any_locked_q, dbg_q;
   logic [7:0] shadow_q, data_q, mem_rdata, mem_wdata;
   logic [AW-1:0] addr_q, cnt_q, end_q, mem_addr, req_addr;
   logic take_fw, take_dbg, who_dbg, pc_lk, external_data_ram_path, fin_deny, mem_en, mem_we;
   fsac_op_e req_op;
   fsac_verdict_e verdict;

   // judge one access; reads the lock and supply state
   function automatic fsac_verdict_e judge(input logic dbg, input fsac_op_e op,
                                           input logic [AW-1:0] a, input logic pc_locked);
      logic rsv, lkpg, lkb_mod;
      rsv = a > LOCK_ADDR;
      lkpg = a[AW-1:PW] == LOCK_PG;
      lkb_mod = a == LOCK_ADDR && op == OP_WRITE && shadow_q != ERASED;
      if (op == OP_FULL) begin
         judge = dbg ? V_ALLOW : V_FLASH_ERROR_RESET;
      end else if (rsv) begin
         judge = dbg ? V_DENY : V_FLASH_ERROR_RESET;
      end else if (!dbg && op != OP_READ && !(mon_en_q && mon_rst_q)) begin
         judge = V_FLASH_ERROR_RESET;
      end else if (lkb_mod) begin
         judge = dbg ? V_DENY : V_FLASH_ERROR_RESET;
      end else if (lkpg && op == OP_ERASE) begin
         judge = dbg ? (any_locked_q ? V_DENY : V_ALLOW) : V_FLASH_ERROR_RESET;
      end else if (!any_locked_q) begin
         judge = V_ALLOW;
      end else begin
         judge = dbg ? V_DENY : (pc_locked ? V_ALLOW : V_FLASH_ERROR_RESET);
      end
   endfunction : judge

   // request selection: firmware wins a tie
   always_comb begin
      take_fw = st_q == ST_IDLE && fw_req;
      take_dbg = st_q == ST_IDLE && !fw_req && dbg_req;
      who_dbg = st_q == ST_IDLE ? take_dbg : dbg_q;
      req_addr = take_dbg ? dbg_addr : fw_addr;
      pc_lk = any_locked_q && fw_pc <= LOCK_ADDR;
      if (take_dbg) begin
         req_op = dbg_op;
      end else if (fw_kind == K_EXT_WR) begin
         req_op = see_q ? OP_ERASE : OP_WRITE;
      end else begin
         req_op = OP_READ;
      end
      // external reads, and external writes without the enable, are ram traffic
      external_data_ram_path = take_fw && (fw_kind == K_EXT_RD || (fw_kind == K_EXT_WR && !swe_q));
      verdict = judge(take_dbg, req_op, req_addr, pc_lk);
   end

   // next state
   always_comb begin
      st_d = st_q;
      fin_deny = 1'b0;
      case (st_q)
         ST_INIT: st_d = ST_INITW;
         ST_INITW: st_d = ST_IDLE;
         ST_IDLE: begin
            if (external_data_ram_path) begin
               st_d = ST_DONE;
            end else if (take_fw || take_dbg) begin
               if (verdict == V_FLASH_ERROR_RESET) begin
                  st_d = ST_FERR;
               end else if (verdict == V_DENY) begin
                  st_d = ST_DONE;
                  fin_deny = 1'b1;
               end else if (req_op == OP_READ) begin
                  st_d = ST_READ;
               end else if (take_fw && key_q != KEY_OPEN) begin
                  st_d = ST_DONE;
                  fin_deny = 1'b1;
               end else if (req_op == OP_WRITE) begin
                  st_d = ST_WREAD;
               end else begin
                  st_d = ST_ERASE;
               end
            end
         end
         ST_READ: st_d = ST_RWAIT;
         ST_RWAIT: st_d = ST_DONE;
         ST_WREAD: st_d = ST_WRITE;
         ST_WRITE: st_d = ST_DONE;
         ST_ERASE: begin
            if (cnt_q == end_q) begin
               st_d = ST_DONE;
            end
         end
         ST_DONE: st_d = ST_IDLE;
         ST_FERR: st_d = ST_INIT;
         default: st_d = ST_INIT;
      endcase
   end

   // state and captured request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_INIT;
         addr_q <= '0;
         data_q <= '0;
         dbg_q <= 1'b0;
         cnt_q <= '0;
         end_q <= '0;
      end else begin
         st_q <= st_d;
         if (st_q == ST_IDLE) begin
            addr_q <= req_addr;
            data_q <= take_dbg ? dbg_wdata : fw_wdata;
            dbg_q <= take_dbg;
            // erase range: one page, or the whole array for a full erase
            cnt_q <= req_op == OP_FULL ? '0 : {req_addr[AW-1:PW], {PW{1'b0}}};
            end_q <= req_op == OP_FULL ? '1 : {req_addr[AW-1:PW], {PW{1'b1}}};
         end else if (st_q == ST_ERASE) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // flash array controls; a write can only clear bits
   always_comb begin
      mem_en = st_q == ST_INIT || st_q == ST_READ || st_q == ST_WREAD
               || st_q == ST_WRITE || st_q == ST_ERASE;
      mem_we = st_q == ST_WRITE || st_q == ST_ERASE;
      mem_addr = st_q == ST_INIT ? LOCK_ADDR : (st_q == ST_ERASE ? cnt_q : addr_q);
      mem_wdata = st_q == ST_ERASE ? ERASED : (mem_rdata & data_q);
   end

   fsac_mem #(.AW(AW), .DW(8)) u_mem (
      .clk(clk),
      .rstn(rstn),
      .en(mem_en),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // lock state is sampled only at start-up, so a new lock waits for a reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         any_locked_q <= 1'b1;
         shadow_q <= ERASED;
      end else if (st_q == ST_INITW) begin
         any_locked_q <= mem_rdata != ERASED;
         shadow_q <= mem_rdata;
      end else if (st_q == ST_WRITE && addr_q == LOCK_ADDR) begin
         shadow_q <= shadow_q & data_q;
      end else if (st_q == ST_ERASE && cnt_q == LOCK_ADDR) begin
         shadow_q <= ERASED;
      end
   end

   // key sequence; one modify consumes it, any misstep kills it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         key_q <= KEY_IDLE;
      end else if (st_q == ST_FERR) begin
         key_q <= KEY_IDLE;
      end else if (take_fw && !external_data_ram_path && verdict == V_ALLOW && req_op != OP_READ) begin
         key_q <= key_q == KEY_OPEN ? KEY_IDLE : KEY_DEAD;
      end else if (reg_wr && reg_addr == REG_KEY) begin
         if (key_q == KEY_IDLE && reg_wdata == KEY_FIRST) begin
            key_q <= KEY_HALF;
         end else if (key_q == KEY_HALF && reg_wdata == KEY_SECOND) begin
            key_q <= KEY_OPEN;
         end else begin
            key_q <= KEY_DEAD;
         end
      end
   end

   // store enables; a flash error restart clears them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         swe_q <= STORE_RST;
         see_q <= STORE_RST;
      end else if (st_q == ST_FERR) begin
         swe_q <= STORE_RST;
         see_q <= STORE_RST;
      end else if (reg_wr && reg_addr == REG_STORE) begin
         swe_q <= reg_wdata[SWE_BIT];
         see_q <= reg_wdata[SEE_BIT];
      end
   end

   // supply monitor enables come up on at power-on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mon_en_q <= MON_RST;
         mon_rst_q <= MON_RST;
      end else begin
         if (reg_wr && reg_addr == REG_SUPPLY) begin
            mon_en_q <= reg_wdata[MONEN_BIT];
         end
         // the power-on bit written as one arms the monitor reset source
         if (reg_wr && reg_addr == REG_RSRC) begin
            mon_rst_q <= reg_wdata[PORF_BIT];
         end
      end
   end

   // reset cause flags; only rstn counts as power-on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         por_q <= PORF_RST;
         ferr_q <= FERR_RST;
      end else if (st_q == ST_FERR) begin
         por_q <= 1'b0;
         ferr_q <= 1'b1;
      end
   end

   // register read data, valid the cycle after the strobe only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               REG_STORE: reg_rdata <= {6'h00, see_q, swe_q};
               REG_KEY: reg_rdata <= {6'h00, key_q};
               REG_RSRC: reg_rdata <= {1'b0, ferr_q, 4'h0, mon_rst_q, por_q};
               REG_SUPPLY: reg_rdata <= {7'h00, mon_en_q};
               REG_LOCK: reg_rdata <= {7'h00, any_locked_q};
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // requester answers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fw_ack <= 1'b0;
         dbg_ack <= 1'b0;
         dbg_deny <= 1'b0;
         external_data_ram_req <= 1'b0;
         cpu_stall <= 1'b0;
         flash_error_reset <= 1'b0;
         fw_rdata <= '0;
         dbg_rdata <= '0;
      end else begin
         fw_ack <= st_d == ST_DONE && st_q != ST_DONE && !who_dbg;
         dbg_ack <= st_d == ST_DONE && st_q != ST_DONE && who_dbg;
         dbg_deny <= fin_deny && take_dbg;
         external_data_ram_req <= external_data_ram_path;
         // code and interrupt service wait out any modify
         cpu_stall <= st_d == ST_WREAD || st_d == ST_WRITE || st_d == ST_ERASE;
         flash_error_reset <= st_d == ST_FERR;
         if (st_q == ST_RWAIT && !dbg_q) begin
            fw_rdata <= mem_rdata;
         end
         if (st_q == ST_RWAIT && dbg_q) begin
            dbg_rdata <= mem_rdata;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence restart_s;
      flash_error_reset ##1 st_q == ST_INIT ##1 st_q == ST_INITW;
   endsequence

   write_gate_a: assert property (st_q == ST_WRITE && !dbg_q |-> swe_q && !see_q)
      else $error("firmware byte write without write enable");
   erase_gate_a: assert property (st_q == ST_ERASE && !dbg_q |-> swe_q && see_q)
      else $error("firmware erase without both enables");
   external_data_ram_route_a: assert property (take_fw && fw_kind == K_EXT_RD |=> external_data_ram_req && fw_ack && !cpu_stall)
      else $error("external read not sent to ram");
   debug_quiet_a: assert property (take_dbg |=> !flash_error_reset ##1 !flash_error_reset)
      else $error("debug access caused a reset");
   locked_debug_a: assert property (take_dbg && any_locked_q && dbg_op != OP_FULL
                                    |=> dbg_ack && dbg_deny)
      else $error("debug reached a locked page");
   error_restart_a: assert property (st_q == ST_FERR |-> restart_s)
      else $error("flash error restart sequence broken");
   error_flag_a: assert property (st_q == ST_FERR |=> ferr_q && !por_q && !swe_q)
      else $error("flash error flag not set");
   supply_gate_a: assert property (take_fw && fw_kind == K_EXT_WR && swe_q
                                   && !(mon_en_q && mon_rst_q) |=> st_q == ST_FERR)
      else $error("modify without supply monitor did not reset");
   erase_stall_a: assert property (st_q == ST_ERASE |-> cpu_stall)
      else $error("code not stalled during erase");
   lock_late_a: assert property ($changed(any_locked_q) |-> $past(st_q) == ST_INITW)
      else $error("lock state changed outside start-up");
   key_spent_a: assert property (st_q == ST_IDLE && st_d == ST_WREAD |=> key_q != KEY_OPEN)
      else $error("key not consumed by a write");
endmodule : fsac_top

// [fsac_req.sv]
// requester model: firmware core and serial debug programmer on the far side
// assumes same clock as the access block; tasks are called by the bench
`timescale 1ns/1ps
module fsac_req import fsac_pkg::*; #(
   parameter int AW = 12
) (
   // clock
   input wire logic clk,
   // firmware side
   output logic fw_req,
   output fsac_kind_e fw_kind,
   output logic [AW-1:0] fw_addr,
   output logic [7:0] fw_wdata,
   output logic [AW-1:0] fw_pc,
   input wire logic [7:0] fw_rdata,
   input wire logic fw_ack,
   input wire logic external_data_ram_req,
   input wire logic flash_error_reset,
   // debug side
   output logic dbg_req,
   output fsac_op_e dbg_op,
   output logic [AW-1:0] dbg_addr,
   output logic [7:0] dbg_wdata,
   input wire logic [7:0] dbg_rdata,
   input wire logic dbg_ack,
   input wire logic dbg_deny
);
   // idle at time zero
   initial begin
      fw_req = 1'b0;
      fw_kind = K_CODE_RD;
      fw_addr = '0;
      fw_wdata = 8'h00;
      fw_pc = '0;
      dbg_req = 1'b0;
      dbg_op = OP_READ;
      dbg_addr = '0;
      dbg_wdata = 8'h00;
   end
   // firmware access: held until ack or error reset; res 0 ack, 1 ram, 3 reset
   // the clock source is internal, so no oscillator switch is needed
   task automatic fw_do(input fsac_kind_e k, input logic [AW-1:0] a, input logic [AW-1:0] pc,
                        input logic [7:0] d, output logic [7:0] res, output logic [7:0] rd);
      int n;
      n = 0;
      res = 8'hee;
      rd = 8'h00;
      @(posedge clk);
      fw_req <= 1'b1;
      fw_kind <= k;
      fw_addr <= a;
      fw_wdata <= d;
      fw_pc <= pc;
      while (n < 5000 && res === 8'hee) begin
         @(posedge clk);
         n++;
         if (flash_error_reset === 1'b1) res = 8'h03;
         else if (fw_ack === 1'b1) begin
            res = (external_data_ram_req === 1'b1) ? 8'h01 : 8'h00;
            rd = fw_rdata;
         end
      end
      // released lines must not keep the old value
      fw_req <= 1'b0;
      fw_addr <= ~a;
      fw_wdata <= ~d;
      repeat (4) @(posedge clk);
   endtask : fw_do
   // debug access: res 0 done, 2 refused
   task automatic dbg_do(input fsac_op_e o, input logic [AW-1:0] a, input logic [7:0] d,
                         output logic [7:0] res, output logic [7:0] rd);
      int n;
      n = 0;
      res = 8'hee;
      rd = 8'h00;
      @(posedge clk);
      dbg_req <= 1'b1;
      dbg_op <= o;
      dbg_addr <= a;
      dbg_wdata <= d;
      while (n < 5000 && res === 8'hee) begin
         @(posedge clk);
         n++;
         if (dbg_ack === 1'b1) begin
            res = (dbg_deny === 1'b1) ? 8'h02 : 8'h00;
            rd = dbg_rdata;
         end
      end
      dbg_req <= 1'b0;
      dbg_addr <= ~a;
      dbg_wdata <= ~d;
      repeat (4) @(posedge clk);
   endtask : dbg_do
endmodule : fsac_req

// [flash_security_access_control_tb_top.sv]
// testbench for the flash access block: register tasks plus firmware/debug traffic
// assumes a 4 KiB flash, lock byte at 3583, reserved area from 3584
`timescale 1ns/1ps
module flash_security_access_control_tb_top import fsac_pkg::*;;
   localparam int AW = 12;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, fw_rdata, fw_wdata, dbg_rdata, dbg_wdata;
   logic reg_wr, reg_rd, fw_req, fw_ack, external_data_ram_req, cpu_stall, flash_error_reset;
   logic dbg_req, dbg_ack, dbg_deny;
   fsac_kind_e fw_kind;
   fsac_op_e dbg_op;
   logic [AW-1:0] fw_addr, fw_pc, dbg_addr;
   logic [7:0] res, fr;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int stall_n = 0;
   // 125 MHz
   always #4 clk = ~clk;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   fsac_top #(.FLASH_SIZE(4096), .PAGE_SIZE(512), .USER_SIZE(3584)) dut (
      .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fw_req(fw_req), .fw_kind(fw_kind), .fw_addr(fw_addr),
      .fw_wdata(fw_wdata), .fw_pc(fw_pc), .fw_rdata(fw_rdata), .fw_ack(fw_ack), .external_data_ram_req(external_data_ram_req),
      .cpu_stall(cpu_stall), .flash_error_reset(flash_error_reset), .dbg_req(dbg_req),
      .dbg_op(dbg_op), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
      .dbg_ack(dbg_ack), .dbg_deny(dbg_deny));
   fsac_req #(.AW(AW)) u_req (
      .clk(clk), .fw_req(fw_req), .fw_kind(fw_kind), .fw_addr(fw_addr), .fw_wdata(fw_wdata),
      .fw_pc(fw_pc), .fw_rdata(fw_rdata), .fw_ack(fw_ack), .external_data_ram_req(external_data_ram_req),
      .flash_error_reset(flash_error_reset), .dbg_req(dbg_req), .dbg_op(dbg_op),
      .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .dbg_ack(dbg_ack),
      .dbg_deny(dbg_deny));
   task automatic test_done;
      if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // power-on reset, then the two init cycles plus margin
   task automatic rst;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : rst
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      chk("reg_rdata", reg_rdata, exp);
   endtask : rd_chk
   task automatic key;
      wr(REG_KEY, KEY_FIRST);
      wr(REG_KEY, KEY_SECOND);
   endtask : key
   task automatic fw(input fsac_kind_e k, input int a, input int pc, input logic [7:0] d,
                     input logic [7:0] exp);
      u_req.fw_do(k, a[AW-1:0], pc[AW-1:0], d, res, fr);
      chk("fw outcome", res, exp);
   endtask : fw
   task automatic dbg(input fsac_op_e o, input int a, input logic [7:0] exp);
      u_req.dbg_do(o, a[AW-1:0], 8'h00, res, fr);
      chk("dbg outcome", res, exp);
   endtask : dbg
   // hang guard well above the longest expected run
   always @(posedge clk) begin
      cyc++;
      // cycles of code stall, checked against the length of one byte write and one page erase
      if (cpu_stall === 1'b1) begin
         stall_n++;
      end
      if (cyc == 40000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      rst();
      rd_chk(REG_RSRC, 8'h03);
      rd_chk(REG_SUPPLY, 8'h01);
      rd_chk(REG_STORE, 8'h00);
      rd_chk(8'h20, 8'h00);
      // without write enable external traffic goes to ram
      fw(K_EXT_WR, 5, 0, 8'h3c, 8'h01);
      fw(K_EXT_RD, 5, 0, 8'h00, 8'h01);
      fw(K_CODE_RD, 5, 0, 8'h00, 8'h00);
      chk("fw_rdata", fr, ERASED);
      wr(REG_STORE, 8'h01);
      key();
      rd_chk(REG_KEY, 8'h02);
      fw(K_EXT_WR, 5, 0, 8'h3c, 8'h00);
      chk("cpu_stall cycles", 8'(stall_n), 8'h02);
      rd_chk(REG_KEY, 8'h00);
      fw(K_CODE_RD, 5, 0, 8'h00, 8'h00);
      chk("fw_rdata", fr, 8'h3c);
      // modify without key is refused and kills the key
      fw(K_EXT_WR, 5, 0, 8'h00, 8'h00);
      key();
      rd_chk(REG_KEY, 8'h03);
      fw(K_CODE_RD, 5, 0, 8'h00, 8'h00);
      chk("fw_rdata", fr, 8'h3c);
      rst();
      wr(REG_STORE, 8'h03);
      key();
      stall_n = 0;
      fw(K_EXT_WR, 511, 0, 8'h00, 8'h00);
      chk("cpu_stall page erase", 8'(stall_n == PAGE_BYTES), 8'h01);
      fw(K_CODE_RD, 5, 0, 8'h00, 8'h00);
      chk("fw_rdata", fr, ERASED);
      wr(REG_STORE, 8'h02);
      key();
      fw(K_EXT_WR, 5, 0, 8'h00, 8'h01);
      rst();
      // supply monitor off turns a modify into an error reset
      wr(REG_SUPPLY, 8'h00);
      wr(REG_STORE, 8'h01);
      key();
      fw(K_EXT_WR, 6, 0, 8'h00, 8'h03);
      rd_chk(REG_RSRC, 8'h42);
      rd_chk(REG_STORE, 8'h00);
      wr(REG_RSRC, 8'h03);
      wr(REG_SUPPLY, 8'h01);
      dbg(OP_READ, 3600, 8'h02);
      fw(K_CODE_RD, 3600, 0, 8'h00, 8'h03);
      dbg(OP_READ, 3583, 8'h00);
      chk("dbg_rdata", fr, ERASED);
      // lock byte written by code waits for the next reset
      wr(REG_STORE, 8'h01);
      key();
      fw(K_EXT_WR, 3583, 0, 8'h00, 8'h00);
      rd_chk(REG_LOCK, 8'h00);
      dbg(OP_READ, 5, 8'h00);
      rst();
      rd_chk(REG_LOCK, 8'h01);
      dbg(OP_READ, 5, 8'h02);
      dbg(OP_READ, 3583, 8'h02);
      dbg(OP_ERASE, 3583, 8'h02);
      dbg(OP_WRITE, 3583, 8'h02);
      fw(K_CODE_RD, 3583, 0, 8'h00, 8'h00);
      chk("fw_rdata", fr, 8'h00);
      fw(K_CODE_RD, 5, 3600, 8'h00, 8'h03);
      wr(REG_STORE, 8'h03);
      key();
      fw(K_EXT_WR, 3583, 0, 8'h00, 8'h03);
      dbg(OP_FULL, 0, 8'h00);
      rst();
      rd_chk(REG_LOCK, 8'h00);
      dbg(OP_READ, 3583, 8'h00);
      chk("dbg_rdata", fr, ERASED);
      // debug write and page erase of an unlocked page need no key
      dbg(OP_WRITE, 7, 8'h00);
      dbg(OP_READ, 7, 8'h00);
      chk("dbg_rdata", fr, 8'h00);
      dbg(OP_ERASE, 7, 8'h00);
      dbg(OP_READ, 7, 8'h00);
      chk("dbg_rdata", fr, ERASED);
      test_done();
   end
endmodule : flash_security_access_control_tb_top
